// ==== design/bus_lock_pkg.sv ====
// What this block does
// - single byte accesses always go indivisibly
// - aligned two-byte accesses go indivisibly
// - aligned four-byte accesses go indivisibly
// - later generations: aligned eight-byte accesses indivisible
// - later: uncached two-byte within lane group indivisible
// - one generation: unaligned cached within line indivisible
// - boundary-straddling cacheable accesses may split
// - mark split pieces with bus control indications
// - finish atomic transaction before granting others
// - lock bus for non-atomic read-modify-write
// - latest generation only: cached locked ops that fit one piece stay in cache
// - hold lock across all cycles of operand
package bus_lock_pkg;
    // ------------------------------------------------------------
    // widths and geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;          // physical address width
    localparam int LANE_BYTES = 4;       // 32-bit data bus lane group
    localparam int QWORD_BYTES = 8;      // 64-bit boundary
    localparam int LINE_BYTES = 32;      // cache line
    localparam int PAGE_BYTES = 4096;    // page
    localparam int MAX_PIECES = 3;       // piece bound; an 8-byte access splits into 2 at most

    // ------------------------------------------------------------
    // generation encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GEN_BASE = 2'b00,                // byte/word/dword guarantees only
        GEN_MID = 2'b01,                 // adds quadword and uncached word
        GEN_LINE = 2'b10,                // adds unaligned in-line cached
        GEN_LATE = 2'b11                 // mid set plus cache locking
    } gen_type;

    // one memory request from the core
    typedef struct packed {
        logic [ADDR_W-1:0] addr;         // byte address
        logic [3:0] size;                // 1, 2, 4 or 8 bytes
        logic write;                     // write when set
        logic cacheable;                 // memory type is cacheable
        logic cache_hit;                 // line held in own cache
        logic locked;                    // read-modify-write sequence
    } req_type;

    // one bus cycle presented to the system bus
    typedef struct packed {
        logic [ADDR_W-1:0] addr;         // piece start address
        logic [3:0] size;                // piece length in bytes
        logic write;                     // direction
        logic split;                     // piece of a split access
        logic last;                      // final piece of the access
    } cyc_type;
endpackage

// ==== design/atomic_classifier.sv ====
`timescale 1ns/100ps
`default_nettype none
module atomic_classifier
    import bus_lock_pkg::*;
(
    input wire req_type req_i,
    input wire gen_type gen_i,
    output logic atomic_o,
    output logic [1:0] pieces_o
);
    // ------------------------------------------------------------
    // boundary checks
    // ------------------------------------------------------------
    logic [12:0] end_off;                // offset of last byte in page
    logic aligned;                       // natural alignment
    logic in_lane;                       // fits one 32-bit lane group
    logic in_line;                       // fits one cache line
    logic in_qw;                         // fits one 64-bit bus word
    logic in_page;                       // fits one page
    logic later;                         // later generation set

    always_comb begin
        end_off = {1'b0, req_i.addr[11:0]} + 13'(req_i.size) - 13'h0001;
        aligned = ((req_i.addr[2:0] & 3'(req_i.size - 4'h1)) == 3'h0);
        in_lane = (req_i.addr[1:0] + 3'(req_i.size) <= 3'(LANE_BYTES));
        in_line = ((req_i.addr[4:0] + 6'(req_i.size)) <= 6'(LINE_BYTES));
        in_qw = ((req_i.addr[2:0] + 4'(req_i.size)) <= 4'(QWORD_BYTES));
        in_page = (end_off < 13'(PAGE_BYTES));
        later = (gen_i != GEN_BASE);
    end

    // ------------------------------------------------------------
    // atomicity decision
    // ------------------------------------------------------------
    always_comb begin
        atomic_o = 1'b0;
        if (req_i.size == 4'h1) begin
            atomic_o = 1'b1;
        end else if (req_i.size == 4'h2 && aligned) begin
            atomic_o = 1'b1;
        end else if (req_i.size == 4'h4 && aligned) begin
            atomic_o = 1'b1;
        end else if (req_i.size == 4'h8 && aligned && later) begin
            atomic_o = 1'b1;
        end else if (req_i.size == 4'h2 && !req_i.cacheable && in_lane && later) begin
            atomic_o = 1'b1;
        end else if (gen_i == GEN_LINE && req_i.cacheable && in_line && in_page) begin
            atomic_o = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // piece count: non-atomic accesses split at bus word edges
    // ------------------------------------------------------------
    always_comb begin
        if (atomic_o || in_qw) begin
            pieces_o = 2'd1;
        end else begin
            pieces_o = 2'd2;
        end
    end
endmodule // atomic_classifier
`default_nettype wire

// ==== design/piece_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
module piece_sequencer
    import bus_lock_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire req_type req_i,
    input wire logic [1:0] pieces_i,
    input wire logic ack_i,
    output logic busy_o,
    output logic done_o,
    output cyc_type cyc_o
);
    // ------------------------------------------------------------
    // piece state
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addr_q;           // next piece address
    logic [3:0] left_q;                  // bytes still to move
    logic [1:0] todo_q;                  // pieces still to issue
    logic write_q;                       // direction held
    logic busy_q;                        // sequence running
    logic split_q;                       // access goes out in several pieces

    // one piece per acknowledged bus cycle; pieces never overlap
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            addr_q <= '0;
            left_q <= 4'h0;
            todo_q <= 2'd0;
            write_q <= 1'b0;
            split_q <= 1'b0;
        end else if (start_i && !busy_q) begin
            busy_q <= 1'b1;
            addr_q <= req_i.addr;
            left_q <= req_i.size;
            todo_q <= pieces_i;
            write_q <= req_i.write;
            // every piece of a split access carries the mark, the last one too
            split_q <= (pieces_i != 2'd1);
        end else if (busy_q && ack_i) begin
            if (todo_q == 2'd1) begin
                busy_q <= 1'b0;
            end
            todo_q <= todo_q - 2'd1;
            addr_q <= addr_q + ADDR_W'(cyc_o.size);
            left_q <= left_q - cyc_o.size;
        end
    end

    // bus cycle view of the current piece
    always_comb begin
        cyc_o.addr = addr_q;
        cyc_o.write = write_q;
        cyc_o.split = busy_q && split_q;
        cyc_o.last = busy_q && (todo_q == 2'd1);
        if (todo_q == 2'd1) begin
            cyc_o.size = left_q;
        end else begin
            cyc_o.size = 4'(QWORD_BYTES) - {1'b0, addr_q[2:0]};
        end
    end

    always_comb begin
        busy_o = busy_q;
        done_o = busy_q && ack_i && (todo_q == 2'd1);
    end
endmodule // piece_sequencer
`default_nettype wire

// ==== design/atomic_access_bus_lock.sv ====
`timescale 1ns/100ps
`default_nettype none
module atomic_access_bus_lock
    import bus_lock_pkg::*;
#(
    parameter gen_type GEN = GEN_LATE
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire req_type req_i,
    input wire logic lock_end_i,
    input wire logic bus_grant_i,
    input wire logic bus_ack_i,
    output logic req_ready_o,
    output logic done_o,
    output logic atomic_o,
    output logic bus_req_o,
    output cyc_type cyc_o,
    output logic bus_lock_o,
    output logic cache_lock_o
);
    // ------------------------------------------------------------
    // size check at elaboration
    // ------------------------------------------------------------
    if (ADDR_W < 13) begin : g_chk
        $error("address must cover a page");
    end

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,                 // waiting for a request
        ST_ARB = 2'b01,                  // asking for the bus
        ST_RUN = 2'b10,                  // issuing pieces
        ST_HOLD = 2'b11                  // locked, between accesses
    } state_type;

    state_type state_q;                  // control state
    req_type req_q;                      // captured request
    logic atomic_w;                      // classifier verdict
    logic [1:0] pieces_w;                // classifier piece count
    logic seq_busy;                      // sequencer running
    logic seq_done;                      // last piece acknowledged
    logic seq_start;                     // launch sequencer
    cyc_type seq_cyc;                    // current piece
    logic in_cache;                      // locked op served by the cache
    logic lock_q;                        // bus lock held
    logic lock_seq_q;                    // inside a locked sequence

    atomic_classifier u_class (
        .req_i(req_q),
        .gen_i(GEN),
        .atomic_o(atomic_w),
        .pieces_o(pieces_w)
    );

    piece_sequencer u_seq (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(seq_start),
        .req_i(req_q),
        .pieces_i(pieces_w),
        .ack_i(bus_ack_i),
        .busy_o(seq_busy),
        .done_o(seq_done),
        .cyc_o(seq_cyc)
    );

    // cache locking only for the latest generation and own cached lines
    always_comb begin
        in_cache = (GEN == GEN_LATE) && req_q.locked && req_q.cacheable
            && req_q.cache_hit && (pieces_w == 2'd1);
        seq_start = (state_q == ST_ARB) && bus_grant_i && !in_cache;
    end

    // ------------------------------------------------------------
    // request capture and main sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            req_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE, ST_HOLD: begin
                    if (req_valid_i) begin
                        req_q <= req_i;
                        state_q <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    // cache-local locked ops finish without the bus
                    if (in_cache) begin
                        state_q <= ST_IDLE;
                    end else if (bus_grant_i) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // no new request until every piece is done
                    if (seq_done) begin
                        state_q <= (lock_q && !lock_end_i) ? ST_HOLD : ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // the piece count comes straight from the held request, so a grant that
    // is already standing (lock held between accesses) starts cleanly

    // ------------------------------------------------------------
    // bus lock: held from first locked piece to sequence end
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            lock_q <= 1'b0;
            lock_seq_q <= 1'b0;
        end else if (seq_start && req_q.locked) begin
            lock_q <= 1'b1;
            lock_seq_q <= 1'b1;
        end else if (seq_done && lock_seq_q && lock_end_i) begin
            lock_q <= 1'b0;
            lock_seq_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            req_ready_o <= 1'b0;
            done_o <= 1'b0;
            atomic_o <= 1'b0;
            bus_req_o <= 1'b0;
            cyc_o <= '0;
            bus_lock_o <= 1'b0;
            cache_lock_o <= 1'b0;
        end else begin
            req_ready_o <= (state_q == ST_IDLE || state_q == ST_HOLD) && !req_valid_i;
            done_o <= seq_done || (state_q == ST_ARB && in_cache);
            atomic_o <= atomic_w;
            // keep asking until the last piece is acknowledged
            bus_req_o <= ((state_q == ST_ARB) && !in_cache) || ((state_q == ST_RUN) && !seq_done);
            cyc_o <= seq_cyc;
            // the far arbiter blocks others while this is high
            bus_lock_o <= lock_q || (seq_start && req_q.locked);
            cache_lock_o <= (state_q == ST_ARB) && in_cache;
        end
    end
endmodule // atomic_access_bus_lock
`default_nettype wire

// ==== test/access_lock_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// port checks of the atomic access and lock block
// ------------------------------------------------
module access_lock_checker
    import bus_lock_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire req_type req_i,
    input wire logic lock_end_i,
    input wire logic bus_grant_i,
    input wire logic bus_ack_i,
    input wire logic req_ready_o,
    input wire logic done_o,
    input wire logic atomic_o,
    input wire logic bus_req_o,
    input wire cyc_type cyc_o,
    input wire logic bus_lock_o,
    input wire logic cache_lock_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    chk_done_after_last: assert property (bus_ack_i && cyc_o.last |=> done_o)
        else $error("done missing after last piece");
    chk_no_early_done: assert property (bus_ack_i && !cyc_o.last |=> !done_o)
        else $error("done before last piece");
    chk_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_lock_kept: assert property ($fell(bus_lock_o) |-> done_o || $past(done_o))
        else $error("lock dropped in mid operand");
    chk_lock_cause: assert property ($rose(bus_lock_o) |-> req_i.locked && !req_i.cache_hit)
        else $error("lock without locked miss");
    chk_cache_quiet: assert property (cache_lock_o |-> !bus_lock_o && !bus_req_o)
        else $error("cache lock used the bus");
    chk_byte_atomic: assert property (req_valid_i && req_ready_o && req_i.size == 4'h1
        |-> ##[1:2] atomic_o)
        else $error("byte access not atomic");
    chk_atomic_whole: assert property (atomic_o && bus_ack_i |-> !cyc_o.split && cyc_o.last)
        else $error("atomic access was split");
    chk_ready_idle: assert property (req_ready_o |-> !bus_req_o)
        else $error("ready while on the bus");
endmodule // access_lock_checker

bind atomic_access_bus_lock access_lock_checker u_chk (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i), .lock_end_i(lock_end_i),
    .bus_grant_i(bus_grant_i), .bus_ack_i(bus_ack_i), .req_ready_o(req_ready_o),
    .done_o(done_o), .atomic_o(atomic_o), .bus_req_o(bus_req_o), .cyc_o(cyc_o),
    .bus_lock_o(bus_lock_o), .cache_lock_o(cache_lock_o));
`default_nettype wire

// ==== test/bus_agent_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// arbiter and memory on the shared system bus
// ------------------------------------------------
module bus_agent_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic bus_req_i,
    input wire logic bus_lock_i,
    input wire logic [3:0] delay_i,
    output logic bus_grant_o,
    output logic bus_ack_o
);
    logic [3:0] wait_q; // wait states spent on the current piece
    // grant follows the request; a held lock keeps the other agents out
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            bus_grant_o <= 1'b0;
        end else begin
            bus_grant_o <= bus_req_i | bus_lock_i;
        end
    end
    // one ack per piece; even a delay_i of zero leaves a gap after each ack
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !(bus_grant_o && bus_req_i) || bus_ack_o) begin
            wait_q <= 4'h0;
            bus_ack_o <= 1'b0;
        end else if (wait_q >= delay_i) begin
            bus_ack_o <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // bus_agent_model
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// self-checking bench of the lock block
// ------------------------------------------------
module tb_top;
    import bus_lock_pkg::*;
    typedef struct packed {cyc_type cyc; logic atom;} note_type;
    logic clk_sys_i = 1'b0;
    logic rst_n_i, req_valid_i, lock_end_i, bus_grant_i, bus_ack_i;
    logic req_ready_o, done_o, atomic_o, bus_req_o, bus_lock_o, cache_lock_o;
    req_type req_i;
    cyc_type cyc_o;
    logic [3:0] delay; // ack wait states, varied per access
    logic [31:0] seed;
    int fail_count = 0;
    int samples_checked = 0;
    note_type exp_q[$]; // pieces the bus should see, oldest first
    note_type mon_n;

    always #20 clk_sys_i = ~clk_sys_i;

    atomic_access_bus_lock #(.GEN(GEN_LATE)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .lock_end_i(lock_end_i),
        .bus_grant_i(bus_grant_i), .bus_ack_i(bus_ack_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .atomic_o(atomic_o), .bus_req_o(bus_req_o), .cyc_o(cyc_o),
        .bus_lock_o(bus_lock_o), .cache_lock_o(cache_lock_o));
    bus_agent_model u_agent (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_o),
        .bus_lock_i(bus_lock_o), .delay_i(delay), .bus_grant_o(bus_grant_i),
        .bus_ack_o(bus_ack_i));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // every acked piece is matched against the oldest note
    always @(posedge clk_sys_i) begin
        if (rst_n_i && bus_ack_i) begin
            if (exp_q.size() == 0) begin
                check(64'h1, 64'h0, "unexpected bus piece");
            end else begin
                mon_n = exp_q.pop_front();
                check(64'(cyc_o), 64'(mon_n.cyc), "bus piece");
                check(64'(atomic_o), 64'(mon_n.atom), "atomic verdict");
            end
        end
    end

    // one access; expectations follow the later-generation guarantees
    task automatic access(input logic [31:0] ad, input logic [3:0] sz, input logic cach,
                          input logic hit, input logic lk, input logic lend);
        int lo;
        int wn;
        logic atom;
        logic wr;
        atom = sz == 4'h1 || ad % sz == 0 || (sz == 4'h2 && !cach && ad[1:0] != 2'b11);
        lo = 8 - int'(ad[2:0]);
        seed = xs(seed);
        wr = seed[5];
        wn = 0;
        while (!req_ready_o && wn < 200) begin
            @(posedge clk_sys_i);
            #1;
            wn++;
        end
        if (wn >= 200) begin
            fail_count++;
            end_of_test();
        end
        delay = 4'(seed[2:0]) + 4'h1;
        req_i = '{addr:ad, size:sz, write:wr, cacheable:cach, cache_hit:hit, locked:lk};
        lock_end_i = lend;
        req_valid_i = 1'b1;
        if (lk && hit) begin
            // served in the cache: no bus piece expected
        end else if (!atom && int'(ad[2:0]) + int'(sz) > 8) begin
            exp_q.push_back('{'{ad, 4'(lo), wr, 1'b1, 1'b0}, atom});
            exp_q.push_back('{'{ad + 32'(lo), sz - 4'(lo), wr, 1'b1, 1'b1}, atom});
        end else begin
            exp_q.push_back('{'{ad, sz, wr, 1'b0, 1'b1}, atom});
        end
        @(posedge clk_sys_i);
        #1;
        req_valid_i = 1'b0;
        wn = 0;
        while (!done_o && wn < 200) begin
            @(posedge clk_sys_i);
            #1;
            wn++;
        end
        if (wn >= 200) begin
            fail_count++;
            end_of_test();
        end
        if (lk && hit) check(64'(wn), 64'h1, "cache op latency");
        check(64'(exp_q.size()), 64'h0, "pieces left at done");
        @(posedge clk_sys_i);
        #1;
        check(64'(bus_lock_o), 64'(lk && !hit && !lend), "lock after done");
    endtask

    initial begin
        rst_n_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        lock_end_i = 1'b0;
        delay = 4'h2;
        seed = 32'h7;
        repeat (12) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        access(32'h0000_0107, 4'h1, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0102, 4'h2, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0105, 4'h2, 1'b0, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0103, 4'h2, 1'b0, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0107, 4'h2, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0104, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0106, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0112, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0108, 4'h8, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0FFC, 4'h8, 1'b1, 1'b0, 1'b0, 1'b1);
        access(32'h0000_0206, 4'h4, 1'b1, 1'b0, 1'b1, 1'b0);
        access(32'h0000_0206, 4'h4, 1'b1, 1'b0, 1'b1, 1'b1);
        access(32'h0000_0300, 4'h4, 1'b1, 1'b1, 1'b1, 1'b1);
        // random sizes and offsets, aligned or not
        repeat (40) begin
            seed = xs(seed);
            access({12'h000, seed[19:0]}, 4'h1 << seed[21:20], seed[22], 1'b0, 1'b0, 1'b1);
        end
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
